// File: verilog/temp_alert_pkg.sv
/*
 * Constants shared by the temperature limit and alert logic: register offsets,
 * field positions, reset values and the reading encoding.
 * Assumes a register port driven by a two-wire protocol engine outside the block.
 */
package temp_alert_pkg;

    // ==========================================================================
    // Sizes
    // ==========================================================================
    localparam int NCH = 4;
    localparam int CODE_W = 11;
    localparam int RAW_W = 13;

    // ==========================================================================
    // Register offsets
    // ==========================================================================
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_SETUP = 8'h03;
    localparam logic [7:0] ADDR_ONESHOT = 8'h0F;
    localparam logic [4:0] READING_REGION = 5'h02;
    localparam logic [7:0] ADDR_HI_FLAGS = 8'h18;
    localparam logic [7:0] ADDR_LO_FLAGS = 8'h19;
    localparam logic [7:0] ADDR_CRIT_FLAGS = 8'h1A;
    localparam logic [7:0] ADDR_HYST = 8'h1B;
    localparam logic [7:0] ADDR_COUNT = 8'h1C;
    localparam logic [2:0] LIMIT_REGION = 3'h1;

    // ==========================================================================
    // Field positions
    // ==========================================================================
    localparam int SETUP_MASK_BIT = 7;
    localparam int SETUP_STANDBY_BIT = 6;
    localparam int SETUP_COMPARATOR_BIT = 5;
    localparam int SETUP_EXTENDED_BIT = 2;
    localparam int STATUS_HIGH_BIT = 4;
    localparam int STATUS_LOW_BIT = 3;
    localparam int STATUS_CRIT_BIT = 1;

    // ==========================================================================
    // Reset values
    // ==========================================================================
    localparam logic [7:0] SETUP_RESET = 8'h00;
    localparam logic [7:0] HYST_RESET = 8'h0A;
    localparam logic [2:0] COUNT_RESET = 3'h0;
    localparam logic [7:0] HIGH_LIMIT_RESET = 8'h55;
    localparam logic [7:0] LOW_LIMIT_RESET = 8'h00;
    localparam logic [7:0] CRIT_LIMIT_RESET = 8'h55;

    // ==========================================================================
    // Reading encoding and limit kinds
    // ==========================================================================
    localparam logic [10:0] DEFAULT_MAX_CODE = 11'h3FF;
    localparam logic [10:0] EXTENDED_MAX_CODE = 11'h7FF;
    localparam logic [13:0] EXTENDED_OFFSET = 14'h0200;
    localparam logic [1:0] KIND_HIGH = 2'h0;
    localparam logic [1:0] KIND_LOW = 2'h1;
    localparam logic [1:0] KIND_CRIT = 2'h2;
    localparam logic [1:0] KIND_SPARE = 2'h3;
    localparam logic [3:0] RUN_COUNT_MAX = 4'h8;

endpackage : temp_alert_pkg

// File: verilog/temp_code_format.sv
/*
 * Turns a signed raw reading in eighths of a degree into the 11-bit reading code.
 * Assumes the raw value and the fault flag are stable while they are sampled.
 */
`timescale 1ns/100ps
module temp_code_format (
    // Raw reading
    input wire logic signed [temp_alert_pkg::RAW_W-1:0] raw,
    input wire logic fault,
    // Range selection
    input wire logic extended,
    // Result
    output logic [temp_alert_pkg::CODE_W-1:0] code
);
    import temp_alert_pkg::*;

    logic signed [13:0] shifted;

    always_comb begin
        shifted = 14'(raw) + (extended ? $signed(EXTENDED_OFFSET) : 14'sh0000);
        if (fault) begin
            code = 11'h000;
        end else if (shifted < 14'sh0000) begin
            code = 11'h000;
        end else if (!extended && shifted > $signed({3'h0, DEFAULT_MAX_CODE})) begin
            code = DEFAULT_MAX_CODE;
        end else if (extended && shifted > $signed({3'h0, EXTENDED_MAX_CODE})) begin
            code = EXTENDED_MAX_CODE;
        end else begin
            code = shifted[10:0];
        end
    end

endmodule : temp_code_format

// File: verilog/limit_store.sv
/*
 * Limit memory: high, low and critical limits for each channel, indexed by kind
 * and channel, with a registered bus read port and a registered compare port.
 * Writes that target the spare kind are dropped.
 */
`timescale 1ns/100ps
module limit_store (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Write port
    input wire logic wr_en,
    input wire logic [3:0] wr_index,
    input wire logic [7:0] wr_data,
    // Bus read port
    input wire logic [3:0] bus_index,
    output logic [7:0] bus_data,
    // Compare read port
    input wire logic [1:0] cmp_chan,
    output logic [7:0] cmp_high,
    output logic [7:0] cmp_low,
    output logic [7:0] cmp_crit
);
    import temp_alert_pkg::*;

    typedef struct packed {
        logic [15:0][7:0] mem;
        logic [7:0] bus_data;
        logic [7:0] cmp_high;
        logic [7:0] cmp_low;
        logic [7:0] cmp_crit;
    } store_t;

    store_t st;
    store_t next_st;

    // ==========================================================================
    // Reset contents
    // ==========================================================================
    localparam store_t STORE_RESET = '{
        mem: {{4{8'h00}}, {4{CRIT_LIMIT_RESET}}, {4{LOW_LIMIT_RESET}},
              {4{HIGH_LIMIT_RESET}}},
        bus_data: 8'h00, cmp_high: 8'h00, cmp_low: 8'h00, cmp_crit: 8'h00};

    // ==========================================================================
    // Access
    // ==========================================================================
    always_comb begin
        next_st = st;
        if (wr_en && wr_index[3:2] != KIND_SPARE) begin
            next_st.mem[wr_index] = wr_data;
        end
        next_st.bus_data = st.mem[bus_index];
        next_st.cmp_high = st.mem[{KIND_HIGH, cmp_chan}];
        next_st.cmp_low = st.mem[{KIND_LOW, cmp_chan}];
        next_st.cmp_crit = st.mem[{KIND_CRIT, cmp_chan}];
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= STORE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign bus_data = st.bus_data;
    assign cmp_high = st.cmp_high;
    assign cmp_low = st.cmp_low;
    assign cmp_crit = st.cmp_crit;

endmodule : limit_store

// File: verilog/temp_limit_alert_logic.sv
/*
 * Digital back end of a four-channel remote diode temperature sensor: reading
 * format, limit checks, status flags and the two open-drain alert pins.
 * Assumes a conversion engine on the same clock that hands over one result per
 * channel and a protocol engine that turns bus transfers into register accesses.
 */
`timescale 1ns/100ps
module temp_limit_alert_logic (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Conversion engine
    input wire logic conv_valid,
    input wire logic [1:0] conv_chan,
    input wire logic signed [temp_alert_pkg::RAW_W-1:0] conv_raw,
    input wire logic conv_fault,
    input wire logic conv_cycle_done,
    output logic conv_run,
    output logic conv_start,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Alert pins
    output logic crit_pin_o,
    output logic crit_pin_oe,
    output logic maskable_warning_pin_o,
    output logic maskable_warning_pin_oe
);
    import temp_alert_pkg::*;

    typedef struct packed {
        logic [7:0] setup;
        logic [7:0] hyst;
        logic [2:0] count_cfg;
        logic [NCH-1:0][7:0] upper;
        logic [NCH-1:0][2:0] lower;
        logic [NCH-1:0] hi_flags;
        logic [NCH-1:0] lo_flags;
        logic [NCH-1:0] crit_act;
        logic [NCH-1:0] warn_act;
        logic [NCH-1:0][3:0] run_cnt;
        logic armed;
        logic oneshot_busy;
        logic stage_valid;
        logic [1:0] stage_chan;
        logic [10:0] stage_code;
        logic rd_stage;
        logic rd_from_mem;
        logic [7:0] rd_local;
        logic [7:0] rdata;
        logic rvalid;
        logic run;
        logic start;
        logic warn_pin;
        logic crit_pin;
    } alert_state_t;

    alert_state_t st;
    alert_state_t next_st;

    logic [10:0] fmt_code;
    logic [7:0] mem_bus_data;
    logic [7:0] lim_high;
    logic [7:0] lim_low;
    logic [7:0] lim_crit;
    logic lim_wr;
    logic in_limits;

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic [10:0] release_point(input logic [7:0] limit,
                                                  input logic [7:0] hyst);
        logic [10:0] lim_code;
        logic [10:0] hyst_code;
        lim_code = {limit, 3'h0};
        hyst_code = {hyst, 3'h0};
        release_point = (lim_code > hyst_code) ? 11'(lim_code - hyst_code) : 11'h000;
    endfunction : release_point

    // ==========================================================================
    // Sub-blocks
    // ==========================================================================
    temp_code_format u_format (
        .raw(conv_raw),
        .fault(conv_fault),
        .extended(st.setup[SETUP_EXTENDED_BIT]),
        .code(fmt_code)
    );

    assign in_limits = (reg_addr[7:5] == LIMIT_REGION);
    assign lim_wr = reg_wr && in_limits;

    limit_store u_limits (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(lim_wr),
        .wr_index(reg_addr[3:0]),
        .wr_data(reg_wdata),
        .bus_index(reg_addr[3:0]),
        .bus_data(mem_bus_data),
        .cmp_chan(conv_chan),
        .cmp_high(lim_high),
        .cmp_low(lim_low),
        .cmp_crit(lim_crit)
    );

    // ==========================================================================
    // Next state
    // ==========================================================================
    always_comb begin
        logic [10:0] code;
        logic [1:0] ch;
        logic over_hi;
        logic under_lo;
        logic at_crit;
        logic qualified;
        logic comparator;
        logic hi_clear_ok;
        logic [3:0] cnt;
        logic [7:0] status;
        code = st.stage_code;
        ch = st.stage_chan;
        over_hi = 1'b0;
        under_lo = 1'b0;
        at_crit = 1'b0;
        qualified = 1'b0;
        comparator = st.setup[SETUP_COMPARATOR_BIT];
        hi_clear_ok = 1'b0;
        cnt = 4'h0;
        status = 8'h00;
        next_st = st;
        next_st.start = 1'b0;
        next_st.rvalid = 1'b0;
        next_st.rd_stage = 1'b0;

        // Register writes.
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_SETUP: begin
                    next_st.setup = reg_wdata;
                    if (st.setup[SETUP_STANDBY_BIT] && !reg_wdata[SETUP_STANDBY_BIT]) begin
                        next_st.start = 1'b1;
                    end
                end
                ADDR_ONESHOT: begin
                    if (st.setup[SETUP_STANDBY_BIT] && !st.oneshot_busy) begin
                        next_st.oneshot_busy = 1'b1;
                        next_st.start = 1'b1;
                    end
                end
                ADDR_HYST: begin
                    next_st.hyst = reg_wdata;
                end
                ADDR_COUNT: begin
                    next_st.count_cfg = reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end
        next_st.run = !next_st.setup[SETUP_STANDBY_BIT];
        if (conv_cycle_done) begin
            next_st.oneshot_busy = 1'b0;
        end

        // Register reads: local values are caught now, before any clear.
        status[STATUS_HIGH_BIT] = |st.hi_flags;
        status[STATUS_LOW_BIT] = |st.lo_flags;
        status[STATUS_CRIT_BIT] = |st.crit_act;
        if (reg_rd) begin
            next_st.rd_stage = 1'b1;
            next_st.rd_from_mem = in_limits;
            next_st.rd_local = 8'h00;
            if (reg_addr[7:3] == READING_REGION) begin
                if (reg_addr[0]) begin
                    next_st.rd_local = {st.lower[reg_addr[2:1]], 5'h00};
                end else begin
                    next_st.rd_local = st.upper[reg_addr[2:1]];
                end
            end else begin
                unique case (reg_addr)
                    ADDR_STATUS: next_st.rd_local = status;
                    ADDR_SETUP: next_st.rd_local = st.setup;
                    ADDR_HI_FLAGS: next_st.rd_local = {4'h0, st.hi_flags};
                    ADDR_LO_FLAGS: next_st.rd_local = {4'h0, st.lo_flags};
                    ADDR_CRIT_FLAGS: next_st.rd_local = {4'h0, st.crit_act};
                    ADDR_HYST: next_st.rd_local = st.hyst;
                    ADDR_COUNT: next_st.rd_local = {5'h00, st.count_cfg};
                    default: next_st.rd_local = 8'h00;
                endcase
            end
            hi_clear_ok = !(comparator && st.warn_pin);
            if (reg_addr == ADDR_HI_FLAGS && hi_clear_ok) begin
                next_st.hi_flags = '0;
            end
            if (reg_addr == ADDR_LO_FLAGS) begin
                next_st.lo_flags = '0;
            end
        end
        if (st.rd_stage) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = st.rd_from_mem ? mem_bus_data : st.rd_local;
        end

        // Capture a result; limits are fetched from the store in the same edge.
        next_st.stage_valid = conv_valid && (st.run || st.oneshot_busy);
        if (conv_valid) begin
            next_st.stage_chan = conv_chan;
            next_st.stage_code = fmt_code;
        end

        // One compare per result, after the read clears so that new events win.
        if (st.stage_valid) begin
            over_hi = code > {lim_high, 3'h0};
            under_lo = code <= {lim_low, 3'h0};
            at_crit = code >= {lim_crit, 3'h0};
            cnt = (over_hi || under_lo) ? st.run_cnt[ch] : 4'h0;
            if ((over_hi || under_lo) && cnt < RUN_COUNT_MAX) begin
                cnt = cnt + 4'h1;
            end
            next_st.run_cnt[ch] = cnt;
            qualified = (cnt > {1'b0, st.count_cfg});
            next_st.upper[ch] = code[10:3];
            next_st.lower[ch] = code[2:0];
            if (over_hi) begin
                next_st.hi_flags[ch] = 1'b1;
            end
            if (under_lo) begin
                next_st.lo_flags[ch] = 1'b1;
            end
            if (at_crit) begin
                next_st.crit_act[ch] = 1'b1;
            end else if (code < release_point(lim_crit, st.hyst)) begin
                next_st.crit_act[ch] = 1'b0;
            end
            if (over_hi && qualified) begin
                next_st.warn_act[ch] = 1'b1;
            end else if (code < release_point(lim_high, st.hyst)) begin
                next_st.warn_act[ch] = 1'b0;
            end
        end

        // Warning pin.
        if (comparator) begin
            next_st.hi_flags = next_st.hi_flags | next_st.warn_act;
            next_st.warn_pin = |next_st.warn_act;
            if (st.warn_pin && !next_st.warn_pin) begin
                next_st.hi_flags = '0;
            end
            next_st.armed = 1'b0;
        end else begin
            next_st.armed = (st.armed || qualified) &&
                            (|{next_st.hi_flags, next_st.lo_flags});
            next_st.warn_pin = next_st.armed &&
                               !next_st.setup[SETUP_MASK_BIT];
        end

        // Critical pin ignores every mask and mode bit.
        next_st.crit_pin = |next_st.crit_act;
    end

    // ==========================================================================
    // State register
    // ==========================================================================
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.setup <= SETUP_RESET;
            st.hyst <= HYST_RESET;
            st.count_cfg <= COUNT_RESET;
            st.run <= !SETUP_RESET[SETUP_STANDBY_BIT];
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================================
    // Outputs
    // ==========================================================================
    assign conv_run = st.run;
    assign conv_start = st.start;
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign crit_pin_o = 1'b0;
    assign crit_pin_oe = st.crit_pin;
    assign maskable_warning_pin_o = 1'b0;
    assign maskable_warning_pin_oe = st.warn_pin;

endmodule : temp_limit_alert_logic

// File: tb/temp_alert_sva.sv
/*
 * Checker bound to the ports of the alert logic.
 * Assumes one clock and an active-low reset.
 */
`timescale 1ns/100ps
module temp_alert_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Conversion engine
    input wire logic conv_valid,
    input wire logic conv_run,
    input wire logic conv_start,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // Alert pins
    input wire logic crit_pin_o,
    input wire logic crit_pin_oe,
    input wire logic maskable_warning_pin_o,
    input wire logic maskable_warning_pin_oe
);
    import temp_alert_pkg::*;
    // ==========================================
    // Helper logic
    logic setup_wr;
    logic [7:0] setup_q;
    assign setup_wr = reg_wr && reg_addr == ADDR_SETUP;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            setup_q <= SETUP_RESET;
        end else if (setup_wr) begin
            setup_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // Sequences
    sequence hi_clear_s;
        reg_rd && reg_addr == ADDR_HI_FLAGS && !setup_q[SETUP_COMPARATOR_BIT]
            && !conv_valid && !$past(conv_valid) && !$past(conv_valid, 2);
    endsequence
    sequence quiet_s;
        !conv_valid [*2];
    endsequence
    sequence st_read_s;
        reg_rd && reg_addr == ADDR_STATUS && !conv_valid;
    endsequence
    // ==========================================
    // Assertions
    pins_low_a:
        assert property (crit_pin_o == 1'b0 && maskable_warning_pin_o == 1'b0)
        else $error("Pin data high.");
    crit_cause_a:
        assert property ($changed(crit_pin_oe) |-> $past(conv_valid, 2))
        else $error("Critical pin moved.");
    warn_cause_a:
        assert property ($changed(maskable_warning_pin_oe) |-> $past(conv_valid, 2)
            || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_rd) || $past(reg_rd, 2))
        else $error("Warning pin moved.");
    read_answer_a:
        assert property (reg_rd |-> ##2 reg_rvalid)
        else $error("Read answer missing.");
    start_pulse_a:
        assert property (conv_start |=> !conv_start)
        else $error("Start pulse too long.");
    idle_trigger_a:
        assert property (conv_run && reg_wr && reg_addr == ADDR_ONESHOT |=> !conv_start [*2])
        else $error("Start while running.");
    run_cause_a:
        assert property ($changed(conv_run) |-> $past(setup_wr))
        else $error("Run state moved.");
    comp_hold_a:
        assert property (setup_q[SETUP_COMPARATOR_BIT] && $stable(setup_q)
            && maskable_warning_pin_oe && reg_rd && reg_addr == ADDR_HI_FLAGS
            |-> ##2 reg_rdata != 8'h00)
        else $error("High flags empty.");
    mask_quiet_a:
        assert property (setup_q[SETUP_MASK_BIT] && !setup_q[SETUP_COMPARATOR_BIT]
            && $stable(setup_q) && $past(setup_q, 2) == setup_q |-> !maskable_warning_pin_oe)
        else $error("Masked pin asserted.");
    hi_clear_a:
        assert property (hi_clear_s ##1 quiet_s ##1 st_read_s |-> ##2 !reg_rdata[STATUS_HIGH_BIT])
        else $error("High summary kept.");
endmodule : temp_alert_sva

bind temp_limit_alert_logic temp_alert_sva u_sva (.sys_clk, .rstn, .conv_valid, .conv_run,
    .conv_start, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .crit_pin_o, .crit_pin_oe, .maskable_warning_pin_o, .maskable_warning_pin_oe);

// File: tb/host_model.sv
/*
 * Host register port model: write and read tasks.
 * Assumes the bench shares sys_clk with the block.
 */
`timescale 1ns/100ps
module host_model (
    // Clock
    input wire logic sys_clk,
    // Register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    // ==========================================
    // Bus cycles
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        #1;
        d = reg_rdata;
        v = reg_rvalid;
    endtask : rd
endmodule : host_model

// File: tb/temp_limit_alert_logic_tb_top.sv
/*
 * Self-checking bench for the alert logic.
 * Assumes the host model drives the register port.
 */
`timescale 1ns/100ps
module temp_limit_alert_logic_tb_top;
    import temp_alert_pkg::*;
    logic sys_clk, rstn, conv_valid, conv_fault, conv_cycle_done, conv_run, conv_start;
    logic [1:0] conv_chan;
    logic signed [RAW_W-1:0] conv_raw;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, reg_rvalid;
    logic crit_pin_o, crit_pin_oe, maskable_warning_pin_o, warn;
    int failures, checks, cycles, starts;
    // ==========================================
    // Instances and clock
    temp_limit_alert_logic dut (.sys_clk, .rstn, .conv_valid, .conv_chan, .conv_raw,
        .conv_fault, .conv_cycle_done, .conv_run, .conv_start, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .crit_pin_o, .crit_pin_oe,
        .maskable_warning_pin_o, .maskable_warning_pin_oe(warn));
    host_model host (.sys_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid);
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        starts += int'(conv_start === 1'b1);
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end
    // ==========================================
    // Shared tasks
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input string n, input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        host.rd(a, d, v);
        check("rvalid", v, 1'b1);
        check($sformatf("register %h", a), d, e);
    endtask : rdchk
    task automatic conv(input logic [1:0] ch, input int raw, input logic f);
        @(posedge sys_clk);
        conv_valid <= 1'b1;
        conv_chan <= ch;
        conv_raw <= RAW_W'(raw);
        conv_fault <= f;
        @(posedge sys_clk);
        conv_valid <= 1'b0;
        conv_fault <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : conv
    task automatic do_reset;
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        starts = 0;
    endtask : do_reset
    function automatic logic [10:0] enc(input int raw, input logic ext);
        int v, top;
        v = ext ? raw + 512 : raw;
        top = ext ? 2047 : 1023;
        v = (v < 0) ? 0 : ((v > top) ? top : v);
        return 11'(v);
    endfunction : enc
    // ==========================================
    // Scenarios
    task automatic t_reset;
        check("run", conv_run, 1'b1);
        rdchk(ADDR_SETUP, SETUP_RESET);
        rdchk(ADDR_HYST, HYST_RESET);
        rdchk(8'h20, HIGH_LIMIT_RESET);
        rdchk(8'h25, LOW_LIMIT_RESET);
        rdchk(8'h3A, CRIT_LIMIT_RESET);
        rdchk(8'hFF, 8'h00);
    endtask : t_reset
    task automatic t_format;
        int raws[6] = '{-600, -8, 0, 1, 512, 1600};
        logic [10:0] c;
        for (int e = 0; e < 2; e++) begin
            host.wr(ADDR_SETUP, e ? 8'h04 : 8'h00);
            foreach (raws[i]) begin
                conv(2'h0, raws[i], 1'b0);
                c = enc(raws[i], e[0]);
                rdchk(8'h10, c[10:3]);
                rdchk(8'h11, {c[2:0], 5'h00});
            end
        end
        conv(2'h0, 512, 1'b1);
        rdchk(8'h10, 8'h00);
    endtask : t_format
    task automatic t_limits;
        host.wr(8'h31, 8'h10);
        rdchk(8'h21, 8'h10);
        conv(2'h1, 128, 1'b0);
        check("warn", warn, 1'b0);
        conv(2'h1, 129, 1'b0);
        check("warn", warn, 1'b1);
        rdchk(ADDR_STATUS, 8'h10);
        rdchk(ADDR_HI_FLAGS, 8'h02);
        rdchk(ADDR_STATUS, 8'h00);
        rdchk(ADDR_HI_FLAGS, 8'h00);
        check("warn", warn, 1'b0);
        conv(2'h2, 0, 1'b0);
        rdchk(ADDR_STATUS, 8'h08);
        rdchk(ADDR_LO_FLAGS, 8'h04);
        rdchk(ADDR_LO_FLAGS, 8'h00);
        host.wr(ADDR_SETUP, 8'h80);
        conv(2'h2, 0, 1'b0);
        check("warn", warn, 1'b0);
        rdchk(ADDR_STATUS, 8'h08);
        host.wr(ADDR_SETUP, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1 check("warn", warn, 1'b1);
    endtask : t_limits
    task automatic t_crit;
        int raws[5] = '{159, 160, 150, 144, 143};
        logic [4:0] exp = 5'h0E;
        host.wr(8'h2B, 8'h14);
        host.wr(ADDR_HYST, 8'h02);
        host.wr(ADDR_SETUP, 8'h80);
        foreach (raws[i]) begin
            conv(2'h3, raws[i], 1'b0);
            check("crit", crit_pin_oe, exp[i]);
        end
    endtask : t_crit
    task automatic t_count;
        host.wr(ADDR_COUNT, 8'h02);
        host.wr(8'h20, 8'h01);
        for (int i = 0; i < 3; i++) begin
            conv(2'h0, 100, 1'b0);
            check("warn", warn, i == 2);
        end
        rdchk(ADDR_HI_FLAGS, 8'h01);
    endtask : t_count
    task automatic t_comp;
        host.wr(ADDR_SETUP, 8'h20);
        host.wr(8'h20, 8'h02);
        host.wr(ADDR_HYST, 8'h01);
        conv(2'h0, 17, 1'b0);
        check("warn", warn, 1'b1);
        rdchk(ADDR_HI_FLAGS, 8'h01);
        rdchk(ADDR_HI_FLAGS, 8'h01);
        conv(2'h0, 8, 1'b0);
        check("warn", warn, 1'b1);
        conv(2'h0, 7, 1'b0);
        check("warn", warn, 1'b0);
        rdchk(ADDR_HI_FLAGS, 8'h00);
    endtask : t_comp
    task automatic t_standby;
        host.wr(ADDR_ONESHOT, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1 check("starts", starts, 0);
        host.wr(ADDR_SETUP, 8'h40);
        host.wr(8'h20, 8'h01);
        conv(2'h0, 40, 1'b0);
        rdchk(8'h10, 8'h00);
        rdchk(ADDR_HI_FLAGS, 8'h00);
        host.wr(ADDR_ONESHOT, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1 check("starts", starts, 1);
        conv(2'h0, 40, 1'b0);
        rdchk(8'h10, 8'h05);
        rdchk(ADDR_HI_FLAGS, 8'h01);
        @(posedge sys_clk);
        conv_cycle_done <= 1'b1;
        @(posedge sys_clk);
        conv_cycle_done <= 1'b0;
        conv(2'h0, 80, 1'b0);
        rdchk(8'h10, 8'h05);
        host.wr(ADDR_SETUP, 8'h00);
        repeat (3) @(posedge sys_clk);
        #1 check("starts", starts, 2);
        check("run", conv_run, 1'b1);
    endtask : t_standby
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        {conv_valid, conv_chan, conv_raw, conv_fault, conv_cycle_done} = '0;
        do_reset();
        t_reset();
        t_format();
        do_reset();
        t_limits();
        do_reset();
        t_crit();
        do_reset();
        t_count();
        do_reset();
        t_comp();
        do_reset();
        t_standby();
        give_verdict();
    end
endmodule : temp_limit_alert_logic_tb_top
